// >>> dswc_pkg.sv
// What this block does
// - Action bits read 1 active, 0 inactive
// - Action bits 0-4 flag error classes 0-4
// - Action bit 6 set when speed magnitude below 9
// - Bit 7 positive motion, bit 8 negative motion
// - Bits 11-14 show profile generator state
// - Action bits 5 and 15 read zero
// - Action bit 9 follows first selector condition
// - Action bit 10 follows second selector condition
// - Motion word bits 9/10 follow both selectors
// - Drive-state bit 11 follows second selector
// - Drive-state bits 0-6 show operating states
// - Bits 7-10: class 0, halt, remote, target
// - Bits 12-15: mode, motion error, end, reference
// - Selector codes 0-11 pick monitoring conditions
// - New selector value acts without restart
// - Second selector shares codes, drives bit 11
package dswc_pkg;
  // Parameter addresses of the four words
  localparam logic [15:0] OFS_STATE = 16'h1b04;
  localparam logic [15:0] OFS_MOTION = 16'h1b4e;
  localparam logic [15:0] OFS_SEL_FIRST = 16'h1b6a;
  localparam logic [15:0] OFS_ACTION = 16'h1c08;
  // Selector reset value and highest legal code
  localparam logic [15:0] SEL_FIRST_RST = 16'h000b;
  localparam logic [15:0] SEL_CODE_MAX = 16'h000b;
  // Speed magnitude below which the motor stands still
  localparam logic [31:0] STANDSTILL_LIM = 32'h00000009;
  // Number of error classes
  localparam int ERR_CLASSES = 5;
  // Selector condition codes
  localparam int SEL_NONE = 0;
  localparam int SEL_CUR_BELOW = 1;
  localparam int SEL_VEL_BELOW = 2;
  localparam int SEL_POS_DEV_WIN = 3;
  localparam int SEL_VEL_DEV_WIN = 4;
  localparam int SEL_POS_REG1 = 5;
  localparam int SEL_HW_LIMIT = 9;
  localparam int SEL_CAPT_MOVE = 10;
  localparam int SEL_POS_WIN = 11;
  localparam int SEL_CODES = 12;
  localparam int POS_REG_CHANNELS = 4;
  // Action word bit positions
  localparam int ACT_ERR_LSB = 0;
  localparam int ACT_RSV_LO = 5;
  localparam int ACT_STILL = 6;
  localparam int ACT_POS = 7;
  localparam int ACT_NEG = 8;
  localparam int ACT_SEL1 = 9;
  localparam int ACT_SEL2 = 10;
  localparam int ACT_IDLE = 11;
  localparam int ACT_DECEL = 12;
  localparam int ACT_ACCEL = 13;
  localparam int ACT_CRUISE = 14;
  localparam int ACT_RSV_HI = 15;
  // Drive-state status word bit positions
  localparam int DSW_READY = 0;
  localparam int DSW_SW_ON = 1;
  localparam int DSW_OP_EN = 2;
  localparam int DSW_FAULT = 3;
  localparam int DSW_VOLT = 4;
  localparam int DSW_QSTOP = 5;
  localparam int DSW_ON_DIS = 6;
  localparam int DSW_ERR0 = 7;
  localparam int DSW_HALT = 8;
  localparam int DSW_REMOTE = 9;
  localparam int DSW_TARGET = 10;
  localparam int DSW_INT_LIM = 11;
  localparam int DSW_MODE = 12;
  localparam int DSW_X_ERR = 13;
  localparam int DSW_X_END = 14;
  localparam int DSW_REF_OK = 15;
  // Motion status word bit positions
  localparam int MOT_SEL1 = 9;
  localparam int MOT_SEL2 = 10;

  // Monitoring results a selector can route
  typedef struct packed {
    logic cur_below;
    logic vel_below;
    logic pos_dev_win;
    logic vel_dev_win;
    logic [3:0] pos_reg;
    logic hw_limit;
    logic relative_move_after_capture;
    logic pos_win;
  } dswc_cond_type;

  // Operating state flags of the drive
  typedef struct packed {
    logic ready_on;
    logic switched_on;
    logic op_enabled;
    logic fault;
    logic voltage_en;
    logic quick_stop;
    logic on_disabled;
    logic halt_req;
    logic remote;
    logic target_reached;
    logic mode_specific;
    logic motion_err;
    logic motion_end;
    logic ref_ok;
  } dswc_drive_type;

  // Profile generator state
  typedef enum logic [1:0] {
    PROF_IDLE,
    PROF_DECEL,
    PROF_ACCEL,
    PROF_CRUISE
  } dswc_prof_type;

  // Parameter access request
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [15:0] wdata;
  } dswc_req_type;

  // Parameter access answer
  typedef struct packed {
    logic [15:0] rdata;
    logic ack;
    logic err;
  } dswc_rsp_type;
endpackage

// >>> dswc_cond_select.sv
`timescale 1ns/1ps
// Routes one monitoring result chosen by a selector code
module dswc_cond_select (
  input wire logic [15:0] sel,
  input wire dswc_pkg::dswc_cond_type cond,
  output logic hit
);
  import dswc_pkg::*;

  logic [SEL_CODES-1:0] vec; // Condition indexed by code
  logic in_range; // Code is a legal one

  // Fixed codes
  assign vec[SEL_NONE] = 1'b0;
  assign vec[SEL_CUR_BELOW] = cond.cur_below;
  assign vec[SEL_VEL_BELOW] = cond.vel_below;
  assign vec[SEL_POS_DEV_WIN] = cond.pos_dev_win;
  assign vec[SEL_VEL_DEV_WIN] = cond.vel_dev_win;
  assign vec[SEL_HW_LIMIT] = cond.hw_limit;
  assign vec[SEL_CAPT_MOVE] = cond.relative_move_after_capture;
  assign vec[SEL_POS_WIN] = cond.pos_win;

  // Position register channels 1 to 4
  genvar i;
  generate
    for (i = 0; i < POS_REG_CHANNELS; i++) begin : g_preg
      assign vec[SEL_POS_REG1+i] = cond.pos_reg[i];
    end
  endgenerate

  // Out-of-range codes route nothing
  assign in_range = (sel <= SEL_CODE_MAX);
  assign hit = in_range ? vec[sel[3:0]] : 1'b0;
endmodule

// >>> dswc_top.sv
`timescale 1ns/1ps
// Status word composer with first limit-bit selector
module dswc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire dswc_pkg::dswc_req_type par_req,
  output dswc_pkg::dswc_rsp_type par_rsp,
  input wire logic [4:0] err_class,
  input wire logic [31:0] speed_actual,
  input wire logic move_pos,
  input wire logic move_neg,
  input wire dswc_pkg::dswc_prof_type prof_state,
  input wire dswc_pkg::dswc_drive_type drive_flags,
  input wire dswc_pkg::dswc_cond_type cond,
  input wire logic [15:0] limit_bit_selector_second,
  output logic [15:0] action_word,
  output logic [15:0] drive_state_status_word,
  output logic [15:0] motion_status_word,
  output logic [15:0] limit_bit_selector_first
);
  import dswc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [15:0] sel_first_reg; // First selector code
  logic [15:0] sel_first_next;
  logic [15:0] action_reg; // Action word
  logic [15:0] action_next;
  logic [15:0] state_reg; // Drive-state status word
  logic [15:0] state_next;
  logic [15:0] motion_reg; // Motion status word
  logic [15:0] motion_next;
  dswc_rsp_type rsp_reg; // Access answer
  dswc_rsp_type rsp_next;

  logic sel1_hit; // Condition of first selector
  logic sel2_hit; // Condition of second selector
  logic [31:0] speed_mag; // Speed magnitude
  logic standstill; // Speed magnitude below limit
  logic prof_idle; // Profile state decode
  logic prof_decel;
  logic prof_accel;
  logic prof_cruise;

  logic hit_state; // Address decode
  logic hit_motion;
  logic hit_sel;
  logic hit_action;
  logic mapped; // Any known address
  logic wr_ok; // Legal selector write
  logic access; // Any request this cycle
  logic [15:0] rd_mux; // Read selection

  //////////////////////////////////////////////////////////////////////////
  // Condition routing

  // First selector feeds action and motion bit 9
  dswc_cond_select u_sel_first (
    .sel(sel_first_reg),
    .cond(cond),
    .hit(sel1_hit)
  );

  // Second selector feeds bit 10 and drive-state bit 11
  dswc_cond_select u_sel_second (
    .sel(limit_bit_selector_second),
    .cond(cond),
    .hit(sel2_hit)
  );

  //////////////////////////////////////////////////////////////////////////
  // Motion decode

  // Standstill judged on magnitude so reverse speed counts too
  assign speed_mag = speed_actual[31] ? (~speed_actual + 32'h00000001)
                                      : speed_actual;
  assign standstill = (speed_mag < STANDSTILL_LIM);

  // One-hot profile state
  assign prof_idle = (prof_state == PROF_IDLE);
  assign prof_decel = (prof_state == PROF_DECEL);
  assign prof_accel = (prof_state == PROF_ACCEL);
  assign prof_cruise = (prof_state == PROF_CRUISE);

  //////////////////////////////////////////////////////////////////////////
  // Word assembly

  // Action word, reserved bits left at zero
  always_comb begin
    action_next = 16'h0000;
    action_next[ACT_ERR_LSB +: ERR_CLASSES] = err_class;
    action_next[ACT_STILL] = standstill;
    action_next[ACT_POS] = move_pos;
    action_next[ACT_NEG] = move_neg;
    action_next[ACT_SEL1] = sel1_hit;
    action_next[ACT_SEL2] = sel2_hit;
    action_next[ACT_IDLE] = prof_idle;
    action_next[ACT_DECEL] = prof_decel;
    action_next[ACT_ACCEL] = prof_accel;
    action_next[ACT_CRUISE] = prof_cruise;
  end

  // Drive-state status word
  always_comb begin
    state_next = 16'h0000;
    state_next[DSW_READY] = drive_flags.ready_on;
    state_next[DSW_SW_ON] = drive_flags.switched_on;
    state_next[DSW_OP_EN] = drive_flags.op_enabled;
    state_next[DSW_FAULT] = drive_flags.fault;
    state_next[DSW_VOLT] = drive_flags.voltage_en;
    state_next[DSW_QSTOP] = drive_flags.quick_stop;
    state_next[DSW_ON_DIS] = drive_flags.on_disabled;
    state_next[DSW_ERR0] = err_class[0];
    state_next[DSW_HALT] = drive_flags.halt_req;
    state_next[DSW_REMOTE] = drive_flags.remote;
    state_next[DSW_TARGET] = drive_flags.target_reached;
    state_next[DSW_INT_LIM] = sel2_hit;
    state_next[DSW_MODE] = drive_flags.mode_specific;
    state_next[DSW_X_ERR] = drive_flags.motion_err;
    state_next[DSW_X_END] = drive_flags.motion_end;
    state_next[DSW_REF_OK] = drive_flags.ref_ok;
  end

  // Motion status word, only the routed bits are defined
  always_comb begin
    motion_next = 16'h0000;
    motion_next[MOT_SEL1] = sel1_hit;
    motion_next[MOT_SEL2] = sel2_hit;
  end

  //////////////////////////////////////////////////////////////////////////
  // Parameter access decode

  assign hit_state = (par_req.addr == OFS_STATE);
  assign hit_motion = (par_req.addr == OFS_MOTION);
  assign hit_sel = (par_req.addr == OFS_SEL_FIRST);
  assign hit_action = (par_req.addr == OFS_ACTION);
  assign mapped = hit_state | hit_motion | hit_sel | hit_action;
  assign access = par_req.rd | par_req.wr;

  // Only the selector is writable, and only with a legal code
  assign wr_ok = par_req.wr & hit_sel & (par_req.wdata <= SEL_CODE_MAX);

  // New code takes over at once, no enable sequence
  assign sel_first_next = wr_ok ? par_req.wdata : sel_first_reg;

  // Read selection, unmapped reads give zero
  assign rd_mux = hit_state ? state_reg :
                  hit_motion ? motion_reg :
                  hit_sel ? sel_first_reg :
                  hit_action ? action_reg : 16'h0000;

  // Answer: write wins when both strobes are high
  always_comb begin
    rsp_next.ack = access;
    rsp_next.err = par_req.wr ? ~wr_ok : (par_req.rd & ~mapped);
    rsp_next.rdata = (par_req.rd & ~par_req.wr) ? rd_mux : 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  // Selector holds its factory code after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_first_reg <= SEL_FIRST_RST;
    end else begin
      sel_first_reg <= sel_first_next;
    end
  end

  // Status words refresh every cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      action_reg <= 16'h0000;
      state_reg <= 16'h0000;
      motion_reg <= 16'h0000;
    end else begin
      action_reg <= action_next;
      state_reg <= state_next;
      motion_reg <= motion_next;
    end
  end

  // Access answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign action_word = action_reg;
  assign drive_state_status_word = state_reg;
  assign motion_status_word = motion_reg;
  assign limit_bit_selector_first = sel_first_reg;
  assign par_rsp = rsp_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  // Error class bits track inputs one cycle later
  err_class_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> action_reg[4:0] == $past(err_class))
    else $error("action error class bits wrong");

  // Standstill bit follows speed magnitude
  still_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((speed_actual == 32'h00000008) ##1 $past(rst_n)) |->
      action_reg[ACT_STILL])
    else $error("standstill not set at speed 8");

  // Speed of nine is not standstill
  moving_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (speed_actual == 32'h00000009) |=> !action_reg[ACT_STILL])
    else $error("standstill set at speed 9");

  // Direction bits follow direction inputs
  dir_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> action_reg[ACT_NEG:ACT_POS] ==
      $past({move_neg, move_pos}))
    else $error("direction bits wrong");

  // Exactly one profile bit after the first cycle
  prof_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> $onehot(action_reg[ACT_CRUISE:ACT_IDLE]))
    else $error("profile bits not one-hot");

  // Accelerating profile shows on bit 13
  prof_accel_a: assert property (@(posedge clk) disable iff (!rst_n)
    (prof_state == PROF_ACCEL) |=> action_reg[ACT_ACCEL])
    else $error("accelerate bit missing");

  // Reserved action bits stay low
  reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    !action_reg[ACT_RSV_LO] && !action_reg[ACT_RSV_HI])
    else $error("reserved action bit set");

  // First selector bit identical in both words
  sel_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    action_reg[ACT_SEL1] == motion_reg[MOT_SEL1])
    else $error("first selector bits differ");

  // Second selector bit identical in all three words
  sel_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    action_reg[ACT_SEL2] == motion_reg[MOT_SEL2] &&
    action_reg[ACT_SEL2] == state_reg[DSW_INT_LIM])
    else $error("second selector bits differ");

  // Hardware limit code routes the limit flag
  sel_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_first_reg == 16'h0009) |=>
      action_reg[ACT_SEL1] == $past(cond.hw_limit))
    else $error("limit switch not routed");

  // Code zero feeds a constant zero
  zero_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (limit_bit_selector_second == 16'h0000) |=> !state_reg[DSW_INT_LIM])
    else $error("code 0 routed a condition");

  // Legal write lands and shows two cycles on
  sel_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (par_req.wr && hit_sel && par_req.wdata == 16'h0001) |=>
      (sel_first_reg == 16'h0001) ##1
      ((action_reg[ACT_SEL1] == $past(cond.cur_below)) ||
       $changed(sel_first_reg)))
    else $error("selector write not effective");

  // Illegal selector code refused and flagged
  sel_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (par_req.wr && hit_sel && par_req.wdata > SEL_CODE_MAX) |=>
      $stable(sel_first_reg) && rsp_reg.err && rsp_reg.ack)
    else $error("illegal code accepted");

  // Drive-state low bits mirror operating flags
  state_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> state_reg[DSW_ON_DIS:DSW_READY] ==
      $past({drive_flags.on_disabled, drive_flags.quick_stop,
             drive_flags.voltage_en, drive_flags.fault,
             drive_flags.op_enabled, drive_flags.switched_on,
             drive_flags.ready_on}))
    else $error("operating state bits wrong");

  // Class 0 error appears in both words together
  err0_both_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg[DSW_ERR0] == action_reg[ACT_ERR_LSB])
    else $error("class 0 bits differ");

  // Motion flags in top bits
  state_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> state_reg[DSW_REF_OK:DSW_X_ERR] ==
      $past({drive_flags.ref_ok, drive_flags.motion_end,
             drive_flags.motion_err}))
    else $error("motion flag bits wrong");

  // Every access answered one cycle later
  access_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    access |=> rsp_reg.ack ##1 ($past(access) || !rsp_reg.ack))
    else $error("access not answered");

  // Reverse speed of eight still counts as standstill
  still_neg_a: assert property (@(posedge clk) disable iff (!rst_n)
    (speed_actual == 32'hfffffff8) |=> action_reg[ACT_STILL])
    else $error("standstill not set at reverse speed 8");

  // Idle profile shows on bit 11
  prof_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (prof_state == PROF_IDLE) |=> action_reg[ACT_IDLE])
    else $error("idle bit missing");

  // Decelerating profile shows on bit 12
  prof_decel_a: assert property (@(posedge clk) disable iff (!rst_n)
    (prof_state == PROF_DECEL) |=> action_reg[ACT_DECEL])
    else $error("decelerate bit missing");

  // Constant speed profile shows on bit 14
  prof_cruise_a: assert property (@(posedge clk) disable iff (!rst_n)
    (prof_state == PROF_CRUISE) |=> action_reg[ACT_CRUISE])
    else $error("constant speed bit missing");

  // Second selector routes its chosen condition
  sel2_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (limit_bit_selector_second == 16'h0001) |=>
      state_reg[DSW_INT_LIM] == $past(cond.cur_below))
    else $error("second selector did not route");

  // Codes above the range route nothing
  sel2_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (limit_bit_selector_second > SEL_CODE_MAX) |=> !action_reg[ACT_SEL2])
    else $error("out-of-range code routed");

  // First selector at code zero feeds zero
  sel1_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_first_reg == 16'h0000) |=> !motion_reg[MOT_SEL1])
    else $error("first selector code 0 routed");

  // Halt, remote and target bits mirror their flags
  state_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> state_reg[DSW_TARGET:DSW_HALT] ==
      $past({drive_flags.target_reached, drive_flags.remote,
             drive_flags.halt_req}))
    else $error("halt remote target bits wrong");

  // Motion word carries only the routed bits
  motion_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    motion_reg[15:MOT_SEL2+1] == '0 && motion_reg[MOT_SEL1-1:0] == '0)
    else $error("motion word stray bit");

  // Mode-specific bit mirrors its flag
  state_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> state_reg[DSW_MODE] == $past(drive_flags.mode_specific))
    else $error("mode bit wrong");
endmodule

// >>> dswc_master.sv
`timescale 1ns/1ps
// Fieldbus master issuing one-cycle parameter requests
module dswc_master (
  input wire logic clk,
  output dswc_pkg::dswc_req_type par_req,
  input wire dswc_pkg::dswc_rsp_type par_rsp
);
  import dswc_pkg::*;
  // Idle request lines from time zero
  initial par_req = '0;
  ////////////////////////////////////////////////////////////////////
  // One request cycle; the answer is taken one edge later
  task automatic access(input logic [15:0] addr, input logic rd,
      input logic wr, input logic [15:0] wdata,
      output dswc_rsp_type rsp);
    @(posedge clk);
    par_req <= '{addr: addr, rd: rd, wr: wr, wdata: wdata};
    // Request taken at this edge, so drop it
    @(posedge clk);
    par_req <= '0;
    // Answer stands for this one cycle only
    #1;
    rsp = par_rsp;
  endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dswc_pkg::*;
  // Row of inputs and the words they should give
  typedef struct packed {
    logic [4:0] ec;
    logic [31:0] spd;
    logic pos;
    logic neg;
    dswc_prof_type prof;
    dswc_drive_type fl;
    logic [15:0] act;
    logic [15:0] dsw;
  } dswc_row_type;
  logic clk;
  logic rst_n;
  dswc_req_type par_req;
  dswc_rsp_type par_rsp;
  logic [4:0] err_class;
  logic [31:0] speed_actual;
  logic move_pos;
  logic move_neg;
  dswc_prof_type prof_state;
  dswc_drive_type drive_flags;
  dswc_cond_type cond;
  logic [15:0] sel_second;
  logic [15:0] action_word;
  logic [15:0] drive_state_status_word;
  logic [15:0] motion_status_word;
  logic [15:0] limit_bit_selector_first;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  logic e;
  // Ordinary cases, selectors at code 0
  dswc_row_type rows [7] = '{
    '{5'h00, 32'h0, 1'h0, 1'h0, PROF_IDLE, 14'h0000, 16'h0840, 16'h0000},
    '{5'h1f, 32'h9, 1'h1, 1'h0, PROF_ACCEL, 14'h0000, 16'h209f, 16'h0080},
    '{5'h02, 32'h8, 1'h0, 1'h1, PROF_DECEL, 14'h2000, 16'h1142, 16'h0001},
    '{5'h01, 32'hfffffff8, 1'h0, 1'h0, PROF_CRUISE, 14'h0001, 16'h4041,
      16'h8080},
    '{5'h10, 32'hfffffff7, 1'h0, 1'h0, PROF_IDLE, 14'h0040, 16'h0810,
      16'h0100},
    '{5'h00, 32'h80000000, 1'h1, 1'h1, PROF_DECEL, 14'h3fff, 16'h1180,
      16'hf77f},
    '{5'h00, 32'h7fffffff, 1'h0, 1'h0, PROF_ACCEL, 14'h0008, 16'h2000,
      16'h1000}
  };
  ////////////////////////////////////////////////////////////////////
  // Device under test and fieldbus master
  dswc_top dut (
    .clk(clk), .rst_n(rst_n), .par_req(par_req), .par_rsp(par_rsp),
    .err_class(err_class), .speed_actual(speed_actual),
    .move_pos(move_pos), .move_neg(move_neg), .prof_state(prof_state),
    .drive_flags(drive_flags), .cond(cond),
    .limit_bit_selector_second(sel_second), .action_word(action_word),
    .drive_state_status_word(drive_state_status_word),
    .motion_status_word(motion_status_word),
    .limit_bit_selector_first(limit_bit_selector_first)
  );
  dswc_master u_master (.clk(clk), .par_req(par_req), .par_rsp(par_rsp));
  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [15:0] exp,
      input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Parameter access with expected answer
  task automatic bus(input logic [15:0] a, input logic rd, input logic wr,
      input logic [15:0] wd, input logic [15:0] er, input logic ee);
    dswc_rsp_type r;
    u_master.access(a, rd, wr, wd, r);
    chk("ack", 16'h0001, {15'h0, r.ack});
    chk("err", {15'h0, ee}, {15'h0, r.err});
    chk("rdata", er, r.rdata);
  endtask
  // Condition set that only the given code should route
  function automatic dswc_cond_type pick(input int c);
    dswc_cond_type r;
    r = '0;
    case (c)
      1: r.cur_below = 1'h1;
      2: r.vel_below = 1'h1;
      3: r.pos_dev_win = 1'h1;
      4: r.vel_dev_win = 1'h1;
      5, 6, 7, 8: r.pos_reg[c - 5] = 1'h1;
      9: r.hw_limit = 1'h1;
      10: r.relative_move_after_capture = 1'h1;
      11: r.pos_win = 1'h1;
      // No source: everything raised
      default: r = '1;
    endcase
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'h0;
    err_class = '0;
    speed_actual = '0;
    move_pos = 1'h0;
    move_neg = 1'h0;
    prof_state = PROF_IDLE;
    drive_flags = '0;
    cond = '0;
    sel_second = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk("sel_rst", 16'h000b, limit_bit_selector_first);
    bus(OFS_SEL_FIRST, 1'h1, 1'h0, 16'h0, 16'h000b, 1'h0);
    bus(OFS_SEL_FIRST, 1'h0, 1'h1, 16'h0, 16'h0, 1'h0);
    // Table of ordinary cases
    foreach (rows[i]) begin
      @(posedge clk);
      err_class <= rows[i].ec;
      speed_actual <= rows[i].spd;
      move_pos <= rows[i].pos;
      move_neg <= rows[i].neg;
      prof_state <= rows[i].prof;
      drive_flags <= rows[i].fl;
      @(posedge clk);
      #1;
      chk("action", rows[i].act, action_word);
      chk("state", rows[i].dsw, drive_state_status_word);
    end
    // Reads of the status words, then refusals
    bus(OFS_ACTION, 1'h1, 1'h0, 16'h0, 16'h2000, 1'h0);
    bus(OFS_STATE, 1'h1, 1'h0, 16'h0, 16'h1000, 1'h0);
    bus(OFS_MOTION, 1'h1, 1'h0, 16'h0, 16'h0, 1'h0);
    bus(OFS_ACTION, 1'h0, 1'h1, 16'hffff, 16'h0, 1'h1);
    bus(16'h1b06, 1'h1, 1'h0, 16'h0, 16'h0, 1'h1);
    bus(OFS_SEL_FIRST, 1'h0, 1'h1, 16'h000c, 16'h0, 1'h1);
    bus(OFS_SEL_FIRST, 1'h1, 1'h0, 16'h0, 16'h0, 1'h0);
    // First selector: every code, effective at once
    for (int c = 0; c < SEL_CODES; c++) begin
      @(posedge clk);
      cond <= pick(c);
      bus(OFS_SEL_FIRST, 1'h0, 1'h1, 16'(c), 16'h0, 1'h0);
      @(posedge clk);
      #1;
      e = (c != 0);
      chk("act9", {15'h0, e}, {15'h0, action_word[ACT_SEL1]});
      chk("mot9", {15'h0, e}, {15'h0, motion_status_word[MOT_SEL1]});
      @(posedge clk);
      cond <= ~pick(c);
      @(posedge clk);
      #1;
      chk("act9_off", 16'h0, {15'h0, action_word[ACT_SEL1]});
    end
    // Second selector: every code and beyond the range
    for (int c = 0; c < 16; c++) begin
      @(posedge clk);
      cond <= pick(c);
      sel_second <= 16'(c);
      @(posedge clk);
      #1;
      e = (c >= 1 && c <= 11);
      chk("act10", {15'h0, e}, {15'h0, action_word[ACT_SEL2]});
      chk("mot10", {15'h0, e}, {15'h0, motion_status_word[MOT_SEL2]});
      chk("dsw11", {15'h0, e},
          {15'h0, drive_state_status_word[DSW_INT_LIM]});
      @(posedge clk);
      cond <= ~pick(c);
      @(posedge clk);
      #1;
      chk("dsw11_off", 16'h0,
          {15'h0, drive_state_status_word[DSW_INT_LIM]});
    end
    // Both strobes high acts as a write
    bus(OFS_SEL_FIRST, 1'h1, 1'h1, 16'h0003, 16'h0, 1'h0);
    chk("sel_both", 16'h0003, limit_bit_selector_first);
    // Reset in mid-run restores the factory selector
    bus(OFS_SEL_FIRST, 1'h0, 1'h1, 16'h0005, 16'h0, 1'h0);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk("sel_rst2", 16'h000b, limit_bit_selector_first);
    chk("act_rst2", 16'h0, action_word);
    @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("act_rel", 16'h2000, action_word);
    chk("dsw_rel", 16'h1000, drive_state_status_word);
    test_done();
  end
endmodule
